// File: design/skip_branch_pkg.sv
// Shared constants and types for the conditional skip and branch unit
package skip_branch_pkg;
   // Instruction forms handled by the unit
   typedef enum logic [3:0] {
      OP_SKIP_IO_CLEAR              = 4'h0,
      OP_SKIP_IO_SET                = 4'h1,
      OP_BRANCH_STATUS_BIT_SET      = 4'h2,
      OP_BRANCH_STATUS_BIT_CLEAR    = 4'h3,
      OP_BRANCH_ON_EQUAL            = 4'h4,
      OP_BRANCH_ON_NOT_EQUAL        = 4'h5,
      OP_BRANCH_CARRY_SET           = 4'h6,
      OP_BRANCH_CARRY_CLEAR         = 4'h7,
      OP_BRANCH_SAME_OR_HIGHER      = 4'h8
   } branch_op_e;

   // Controller states
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_BUSY = 1'b1
   } ctrl_state_e;

   // Widths
   localparam int DATA_W   = 8;
   localparam int SEL_W    = 3;
   localparam int OFFS_W   = 7;
   localparam int PC_W     = 14;
   localparam int CYCLE_W  = 2;

   // Status register bit positions
   localparam logic [SEL_W-1:0] STATUS_CARRY_BIT = 3'h0;
   localparam logic [SEL_W-1:0] STATUS_ZERO_BIT  = 3'h1;

   // Program counter advances, in words
   localparam int PC_STEP_NEXT      = 1;
   localparam int PC_STEP_SKIP_ONE  = 2;
   localparam int PC_STEP_SKIP_TWO  = 3;
   localparam int BRANCH_EXTRA      = 1;

   // Execution cycle counts
   localparam logic [CYCLE_W-1:0] CYC_NOT_TAKEN    = 2'h1;
   localparam logic [CYCLE_W-1:0] CYC_BRANCH_TAKEN = 2'h2;
   localparam logic [CYCLE_W-1:0] CYC_SKIP_ONE     = 2'h2;
   localparam logic [CYCLE_W-1:0] CYC_SKIP_TWO     = 2'h3;
   localparam logic [CYCLE_W-1:0] CYC_LAST_WAIT    = 2'h2;
endpackage : skip_branch_pkg

// File: design/branch_cond_if.sv
// Carrier between the controller and the condition evaluator
`timescale 1ns/1ns
`default_nettype none
interface branch_cond_if;
   import skip_branch_pkg::*;
   branch_op_e          op;
   logic [SEL_W-1:0]    bit_sel;
   logic [DATA_W-1:0]   io_value;
   logic [DATA_W-1:0]   status;
   logic                cond_true;
   logic                is_skip;

   modport ctrl (output op, output bit_sel, output io_value, output status,
                 input cond_true, input is_skip);
   modport eval (input op, input bit_sel, input io_value, input status,
                 output cond_true, output is_skip);
endinterface : branch_cond_if
`default_nettype wire

// File: design/branch_cond_eval.sv
// Combinational test of the skip or branch condition
`timescale 1ns/1ns
`default_nettype none
module branch_cond_eval (
   branch_cond_if.eval cif
);
   import skip_branch_pkg::*;

   logic io_bit;
   logic status_bit;

   assign io_bit     = cif.io_value[cif.bit_sel];
   assign status_bit = cif.status[cif.bit_sel];

   always_comb begin
      cif.is_skip   = 1'b0;
      cif.cond_true = 1'b0;
      case (cif.op)
         OP_SKIP_IO_CLEAR: begin
            cif.is_skip   = 1'b1;
            cif.cond_true = ~io_bit;
         end
         OP_SKIP_IO_SET: begin
            cif.is_skip   = 1'b1;
            cif.cond_true = io_bit;
         end
         OP_BRANCH_STATUS_BIT_SET:   cif.cond_true = status_bit;
         OP_BRANCH_STATUS_BIT_CLEAR: cif.cond_true = ~status_bit;
         OP_BRANCH_ON_EQUAL:         cif.cond_true = cif.status[STATUS_ZERO_BIT];
         OP_BRANCH_ON_NOT_EQUAL:     cif.cond_true = ~cif.status[STATUS_ZERO_BIT];
         OP_BRANCH_CARRY_SET:        cif.cond_true = cif.status[STATUS_CARRY_BIT];
         OP_BRANCH_CARRY_CLEAR:      cif.cond_true = ~cif.status[STATUS_CARRY_BIT];
         // Same-or-higher is the carry-clear test under another name
         OP_BRANCH_SAME_OR_HIGHER:   cif.cond_true = ~cif.status[STATUS_CARRY_BIT];
         default: begin
            cif.is_skip   = 1'b0;
            cif.cond_true = 1'b0;
         end
      endcase
   end
endmodule : branch_cond_eval
`default_nettype wire

// File: design/conditional_skip_branch_unit.sv
// Skip and relative-branch decision with program counter update
// What this block does
// - Skip next instruction when I/O bit clear
// - Skip next instruction when I/O bit set
// - Branch by offset plus one if status bit set
// - Branch by offset plus one if status bit clear
// - Carry-clear branch jumps when carry is zero
// - Same-or-higher branch behaves as carry-clear test
`timescale 1ns/1ns
`default_nettype none
module conditional_skip_branch_unit
   import skip_branch_pkg::*;
#(
   parameter int PC_WIDTH     = PC_W,
   parameter int OFFSET_WIDTH = OFFS_W
) (
   // Clock and reset
   input  wire logic                      i_clk,
   input  wire logic                      i_rstn,
   // Request from the instruction decoder
   input  wire logic                      i_valid,
   input  wire skip_branch_pkg::branch_op_e i_op,
   input  wire logic [skip_branch_pkg::SEL_W-1:0]  i_bit_sel,
   input  wire logic [OFFSET_WIDTH-1:0]   i_offset,
   input  wire logic                      i_next_two_word,
   input  wire logic [PC_WIDTH-1:0]       i_pc,
   // Operands
   input  wire logic [skip_branch_pkg::DATA_W-1:0] i_io_value,
   input  wire logic [skip_branch_pkg::DATA_W-1:0] i_status,
   // Answer to the program counter logic
   output logic                           o_ready,
   output logic                           o_done,
   output logic                           o_taken,
   output logic [PC_WIDTH-1:0]            o_pc_next,
   output logic [skip_branch_pkg::CYCLE_W-1:0] o_cycles,
   output logic [skip_branch_pkg::DATA_W-1:0]  o_status
);
   import skip_branch_pkg::*;

   // Offset must fit inside the counter, or branch targets wrap wrongly
   if (PC_WIDTH < OFFSET_WIDTH) begin : pc_width_check
      $error("conditional_skip_branch_unit: PC_WIDTH must cover OFFSET_WIDTH");
   end
   // A one-bit offset would carry a sign and no magnitude
   if (OFFSET_WIDTH < 2) begin : offset_width_check
      $error("conditional_skip_branch_unit: OFFSET_WIDTH must be at least 2");
   end

   // Countdown assumes no multi-cycle form is shorter than the last wait
   if (CYC_BRANCH_TAKEN < CYC_LAST_WAIT || CYC_SKIP_ONE < CYC_LAST_WAIT) begin : cycle_check
      $error("conditional_skip_branch_unit: cycle table shorter than last wait");
   end

   // Word-wrapping add of a small unsigned step
   function automatic logic [PC_WIDTH-1:0] pc_add_step(input logic [PC_WIDTH-1:0] pc,
                                                       input int step);
      logic [PC_WIDTH-1:0] step_w;
      step_w = PC_WIDTH'(step);
      return pc + step_w;
   endfunction : pc_add_step

   // Relative target: signed offset sign-extended onto the counter width
   function automatic logic [PC_WIDTH-1:0] pc_add_offset(input logic [PC_WIDTH-1:0] pc,
                                                         input logic [OFFSET_WIDTH-1:0] k);
      logic [PC_WIDTH-1:0] k_ext;
      k_ext = {{(PC_WIDTH-OFFSET_WIDTH){k[OFFSET_WIDTH-1]}}, k};
      return pc_add_step(pc + k_ext, BRANCH_EXTRA);
   endfunction : pc_add_offset

   branch_cond_if cif ();

   assign cif.op       = i_op;
   assign cif.bit_sel  = i_bit_sel;
   assign cif.io_value = i_io_value;
   assign cif.status   = i_status;

   branch_cond_eval u_eval (
      .cif (cif)
   );

   ctrl_state_e          state_reg;
   logic [CYCLE_W-1:0]   remain_reg;
   logic [PC_WIDTH-1:0]  target_next;
   logic [CYCLE_W-1:0]   cycles_next;
   logic                 accept;
   logic                 skip_taken;
   logic                 branch_taken;
   logic                 multi_cycle;
   logic                 last_wait;

   // Ready is combinational so a new request can land on the edge that ends the completion pulse
   assign o_ready      = (state_reg == ST_IDLE);
   // Requests that meet a busy unit are dropped, not queued
   assign accept       = i_valid & o_ready;
   assign skip_taken   = cif.cond_true & cif.is_skip;
   assign branch_taken = cif.cond_true & ~cif.is_skip;
   assign multi_cycle  = (cycles_next != CYC_NOT_TAKEN);
   assign last_wait    = (remain_reg == '0);

   // Next program counter for the request at the input; wraps at the top
   always_comb begin
      if (branch_taken) begin
         target_next = pc_add_offset(i_pc, i_offset);
      end else if (skip_taken && i_next_two_word) begin
         // Skipped instruction is two words long
         target_next = pc_add_step(i_pc, PC_STEP_SKIP_TWO);
      end else if (skip_taken) begin
         target_next = pc_add_step(i_pc, PC_STEP_SKIP_ONE);
      end else begin
         // Not taken: plain sequential step
         target_next = pc_add_step(i_pc, PC_STEP_NEXT);
      end
   end

   // Execution length of the same request
   always_comb begin
      if (branch_taken) begin
         cycles_next = CYC_BRANCH_TAKEN;
      end else if (skip_taken && i_next_two_word) begin
         // One more cycle to step over the second word
         cycles_next = CYC_SKIP_TWO;
      end else if (skip_taken) begin
         cycles_next = CYC_SKIP_ONE;
      end else begin
         // Not taken: single cycle
         cycles_next = CYC_NOT_TAKEN;
      end
   end

   // Sequencer: idle until a request needs more than one cycle
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         state_reg <= ST_IDLE;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (accept && multi_cycle) begin
                  state_reg <= ST_BUSY;
               end
            end
            ST_BUSY: begin
               // Back to idle on the edge that raises the completion pulse
               if (last_wait) begin
                  state_reg <= ST_IDLE;
               end
            end
            default: begin
               // Unused code: recover to idle
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // Wait cycles still owed before the completion pulse
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         remain_reg <= '0;
      end else if (state_reg == ST_IDLE) begin
         // Lengths above two owe extra wait cycles
         if (accept && multi_cycle) begin
            remain_reg <= cycles_next - CYC_LAST_WAIT;
         end
      end else if (!last_wait) begin
         remain_reg <= remain_reg - CYC_NOT_TAKEN;
      end
   end

   // Completion pulse after the instruction's full cycle count
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_done <= 1'b0;
      end else if (state_reg == ST_IDLE) begin
         // A single-cycle form finishes on its own accept edge
         o_done <= accept && !multi_cycle;
      end else begin
         o_done <= last_wait;
      end
   end

   // Condition outcome, held until the next request is taken
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_taken <= 1'b0;
      end else if (accept) begin
         o_taken <= cif.cond_true;
      end
   end

   // New program counter, held likewise
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_pc_next <= '0;
      end else if (accept) begin
         o_pc_next <= target_next;
      end
   end

   // Execution length reported alongside the target
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_cycles <= '0;
      end else if (accept) begin
         o_cycles <= cycles_next;
      end
   end

   // Flags pass through untouched; none of these forms writes them
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_status <= '0;
      end else if (accept) begin
         o_status <= i_status;
      end
   end
endmodule : conditional_skip_branch_unit
`default_nettype wire

// File: tb/skip_branch_monitor.sv
// Port assertions for the skip and branch unit
`timescale 1ns/1ns
`default_nettype none
module skip_branch_monitor
   import skip_branch_pkg::*;
#(
   parameter int PC_WIDTH     = 14,
   parameter int OFFSET_WIDTH = 7
) (
   // Request side
   input wire logic                    i_clk,
   input wire logic                    i_rstn,
   input wire logic                    i_valid,
   input wire branch_op_e              i_op,
   input wire logic [2:0]              i_bit_sel,
   input wire logic [OFFSET_WIDTH-1:0] i_offset,
   input wire logic                    i_next_two_word,
   input wire logic [PC_WIDTH-1:0]     i_pc,
   input wire logic [7:0]              i_io_value,
   input wire logic [7:0]              i_status,
   // Answer side
   input wire logic                    o_ready,
   input wire logic                    o_done,
   input wire logic                    o_taken,
   input wire logic [PC_WIDTH-1:0]     o_pc_next,
   input wire logic [7:0]              o_status
);
   logic [PC_WIDTH-1:0] tgt;
   logic                hit;
   assign tgt = i_pc + PC_WIDTH'(signed'(i_offset)) + 1'b1;
   assign hit = i_io_value[i_bit_sel] == (i_op == OP_SKIP_IO_SET) && i_op <= OP_SKIP_IO_SET;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   sequence s_acc; i_valid && o_ready; endsequence
   sequence s_jump; o_taken && o_pc_next == $past(tgt) && !o_ready ##1 o_done; endsequence
   AST_SKIP_PC: assert property (
      s_acc ##0 hit |=> o_taken && o_pc_next == PC_WIDTH'($past(i_pc) + 2 + $past(i_next_two_word)))
      else $error("skip target wrong");
   AST_SKIP_LEN: assert property (
      s_acc ##0 hit && i_next_two_word |=> !o_ready ##1 !o_ready && !o_done ##1 o_done)
      else $error("two-word skip length wrong");
   AST_BR_SET: assert property (
      s_acc ##0 i_op == OP_BRANCH_STATUS_BIT_SET && i_status[i_bit_sel] |=> s_jump)
      else $error("set branch wrong");
   AST_BR_CLR: assert property (
      s_acc ##0 i_op == OP_BRANCH_STATUS_BIT_CLEAR && !i_status[i_bit_sel] |=> s_jump)
      else $error("clear branch wrong");
   AST_BR_FALL: assert property (
      s_acc ##0 i_op == OP_BRANCH_STATUS_BIT_CLEAR && i_status[i_bit_sel] |=>
      !o_taken && o_done && o_pc_next == PC_WIDTH'($past(i_pc) + 1))
      else $error("fall through wrong");
   AST_BR_CC: assert property (
      s_acc ##0 (i_op == OP_BRANCH_CARRY_CLEAR || i_op == OP_BRANCH_SAME_OR_HIGHER)
      && !i_status[0] |=> s_jump)
      else $error("carry clear branch wrong");
   AST_BR_FLAG: assert property (
      s_acc ##0 (i_op == OP_BRANCH_ON_EQUAL && i_status[1] || i_op == OP_BRANCH_ON_NOT_EQUAL
      && !i_status[1] || i_op == OP_BRANCH_CARRY_SET && i_status[0]) |=> s_jump)
      else $error("flag branch wrong");
   AST_FLAGS: assert property (
      s_acc |=> o_status == $past(i_status))
      else $error("status changed");
   AST_BUSY_HOLD: assert property (
      !o_ready |=> $stable(o_pc_next) && $stable(o_status) && $stable(o_taken))
      else $error("busy unit took a request");
endmodule : skip_branch_monitor
bind conditional_skip_branch_unit skip_branch_monitor #(
   .PC_WIDTH(PC_WIDTH), .OFFSET_WIDTH(OFFSET_WIDTH)
) i_skip_branch_monitor (
   .i_clk(i_clk), .i_rstn(i_rstn), .i_valid(i_valid), .i_op(i_op), .i_bit_sel(i_bit_sel),
   .i_offset(i_offset), .i_next_two_word(i_next_two_word), .i_pc(i_pc),
   .i_io_value(i_io_value), .i_status(i_status), .o_ready(o_ready), .o_done(o_done),
   .o_taken(o_taken), .o_pc_next(o_pc_next), .o_status(o_status)
);
`default_nettype wire

// File: tb/pc_holder_model.sv
// Program counter holder on the unit's far side
`timescale 1ns/1ns
`default_nettype none
module pc_holder_model #(
   parameter int PC_WIDTH = 14
) (
   // Answer from the unit
   input  wire logic                i_clk,
   input  wire logic                i_rstn,
   input  wire logic                i_done,
   input  wire logic [PC_WIDTH-1:0] i_pc_next,
   // Current program counter
   output logic      [PC_WIDTH-1:0] o_pc
);
   // Commit only on completion, so a busy unit never moves it
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_pc <= '0;
      end else if (i_done) begin
         o_pc <= i_pc_next;
      end
   end
endmodule : pc_holder_model
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the skip and branch unit
`timescale 1ns/1ns
`default_nettype none
`define CHK(name, exp, got) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
   $display("CHECK FAILED %s exp %0h got %0h", name, exp, got); end end
module testbench;
   import skip_branch_pkg::*;
   logic        i_clk = 1'b0;
   logic        i_rstn = 1'b0;
   logic        i_valid = 1'b0;
   branch_op_e  i_op = OP_SKIP_IO_CLEAR;
   logic [2:0]  i_bit_sel = '0;
   logic [6:0]  i_offset = '0;
   logic        i_next_two_word = 1'b0;
   logic [7:0]  i_io_value = '0;
   logic [7:0]  i_status = '0;
   logic [13:0] i_pc, o_pc_next;
   logic        o_ready, o_done, o_taken;
   logic [1:0]  o_cycles;
   logic [7:0]  o_status;
   logic [31:0] lfsr = 32'ha88f6c04;
   int          num_errors = 0;
   int          checks_done = 0;
   always #25 i_clk = ~i_clk;
   conditional_skip_branch_unit i_conditional_skip_branch_unit (
      .i_clk(i_clk), .i_rstn(i_rstn), .i_valid(i_valid), .i_op(i_op), .i_bit_sel(i_bit_sel),
      .i_offset(i_offset), .i_next_two_word(i_next_two_word), .i_pc(i_pc),
      .i_io_value(i_io_value), .i_status(i_status), .o_ready(o_ready), .o_done(o_done),
      .o_taken(o_taken), .o_pc_next(o_pc_next), .o_cycles(o_cycles), .o_status(o_status));
   pc_holder_model i_pc_holder_model (
      .i_clk(i_clk), .i_rstn(i_rstn), .i_done(o_done), .i_pc_next(o_pc_next), .o_pc(i_pc));
   function automatic logic [31:0] next_rand(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : next_rand
   // Result packed as taken, cycle count, new program counter
   function automatic logic [16:0] expect_of(branch_op_e op, logic [26:0] d, logic [13:0] pc);
      logic [7:0]        io = d[10:3];
      logic [7:0]        st = d[18:11];
      logic signed [6:0] k = d[25:19];
      logic              hit;
      case (op)
         OP_SKIP_IO_CLEAR:           hit = !io[d[2:0]];
         OP_SKIP_IO_SET:             hit = io[d[2:0]];
         OP_BRANCH_STATUS_BIT_SET:   hit = st[d[2:0]];
         OP_BRANCH_STATUS_BIT_CLEAR: hit = !st[d[2:0]];
         OP_BRANCH_ON_EQUAL:         hit = st[1];
         OP_BRANCH_ON_NOT_EQUAL:     hit = !st[1];
         OP_BRANCH_CARRY_SET:        hit = st[0];
         OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_OR_HIGHER: hit = !st[0];
         default:                    hit = 1'b0;
      endcase
      if (!hit) return {3'h1, pc + 14'h1};
      if (op <= OP_SKIP_IO_SET) return {1'b1, 2'h2 + 2'(d[26]), pc + 14'h2 + 14'(d[26])};
      return {3'h6, pc + 14'(k) + 14'h1};
   endfunction : expect_of
   task automatic run(input branch_op_e op, input logic [26:0] d);
      logic [16:0] e;
      int          n;
      e = expect_of(op, d, i_pc);
      {i_next_two_word, i_offset, i_status, i_io_value, i_bit_sel} = d;
      i_op = op;
      i_valid = 1'b1;
      @(posedge i_clk);
      #5;
      // Scrambled request held against a busy unit must be dropped
      i_valid = (o_done !== 1'b1);
      i_status = ~i_status;
      `CHK("ready", e[15:14] == 2'h1, o_ready)
      `CHK("taken", e[16], o_taken)
      `CHK("pc", e[13:0], o_pc_next)
      `CHK("status", d[18:11], o_status)
      n = 1;
      while (o_done !== 1'b1 && n < 5) begin
         @(posedge i_clk);
         #5;
         i_valid = (o_done !== 1'b1);
         n++;
      end
      `CHK("done delay", int'(e[15:14]), n)
      `CHK("cycles", e[15:14], o_cycles)
      `CHK("pc held", e[13:0], o_pc_next)
      `CHK("status held", d[18:11], o_status)
      @(posedge i_clk);
      #5;
      `CHK("done pulse", 1'b0, o_done)
   endtask : run
   // Reset with the outputs checked against their idle values
   task automatic reset_for(input int cycles);
      i_rstn = 1'b0;
      repeat (cycles) @(posedge i_clk);
      #5;
      `CHK("reset state", {1'b1, 26'h0}, {o_ready, o_done, o_taken, o_pc_next, o_cycles, o_status})
      i_rstn = 1'b1;
   endtask : reset_for
   task automatic test_done();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : test_done
   initial begin
      reset_for(6);
      // Every form with both outcomes, most negative offset
      for (int i = 0; i < 18; i++) begin
         run(branch_op_e'(4'(i / 2)), {i[0], 7'h40, {16{i[0]}}, 3'(i / 2)});
      end
      // Reset in mid-run, then an undefined form that must fall through
      reset_for(2);
      run(branch_op_e'(4'hf), 27'h7ffffff);
      repeat (300) begin
         lfsr = next_rand(lfsr);
         run(branch_op_e'(lfsr[3:0] % 4'h9), lfsr[30:4]);
      end
      test_done();
   end
   initial begin
      #(50 * 3000);
      num_errors++;
      test_done();
   end
endmodule : testbench
`default_nettype wire
